/* File: scmi_regs.svh */
// register map, opcodes and bit counts for the serial command interpreter
// Overview of operation
// - opcodes: wake 02h, standby 04h, reset 06h, start 08h, stop 0Ah, cal 1Ah, 10h/11h/12h.
// - system and single-read opcodes act at seventh falling edge; register opcodes at eighth.
// - register read commands are ignored while continuous read mode is active.
// - start opcode begins conversions; no effect when conversions already run.
// - stop lets the conversion in progress finish, then no further conversions.
// - stop while conversions are already halted does nothing.
// - continuous read after power-up; each result loads the output shifter automatically.
// - halt opcode ends continuous read; host waits four clocks before next command.
// - single read follows data-ready falling; later commands need no extra wait.
// - single read overlapping the next data-ready finishes with uncorrupted data.
// - register read is 001 plus start address, then 000 plus count minus one.
// - register read drives first register MSB on seventeenth rising serial clock edge.
// - register write is 010 plus start address, then 000 plus count minus one.
`ifndef SCMI_REGS_SVH
`define SCMI_REGS_SVH
// seven-bit prefixes checked at the seventh falling edge
`define SCMI_P7_WAKE 7'h01
`define SCMI_P7_STANDBY 7'h02
`define SCMI_P7_RESET 7'h03
`define SCMI_P7_START 7'h04
`define SCMI_P7_STOP 7'h05
`define SCMI_P7_RDATA 7'h09
`define SCMI_P7_CAL 7'h0d
// full bytes checked at the eighth falling edge
`define SCMI_OP_CONT_READ 8'h10
`define SCMI_OP_HALT_READ 8'h11
`define SCMI_PFX_REG_READ 3'h1
`define SCMI_PFX_REG_WRITE 3'h2
// bit counter values at the decode edges, then output shift lengths for results and registers
`define SCMI_BIT_SYS 3'h6
`define SCMI_BIT_BYTE 3'h7
`define SCMI_DATA_BITS 6'h20
`define SCMI_REG_BITS 6'h08
// register addresses
`define SCMI_ADDR_IDENT 5'h00
`define SCMI_ADDR_RATE 5'h01
`define SCMI_ADDR_REFTST 5'h02
`define SCMI_ADDR_EDCTL 5'h03
`define SCMI_ADDR_EDSTAT 5'h08
`define SCMI_ADDR_CAL 5'h0a
`define SCMI_ADDR_PIN 5'h0b
`define SCMI_ADDR_LAST 5'h0b
// reset values; identity value is arbitrary
`define SCMI_RST_IDENT 8'h50
`define SCMI_RST_RATE 8'h02
`define SCMI_RST_REFTST 8'h80
`define SCMI_RST_EDCTL 8'h10
`define SCMI_RST_CAL 8'h02
`define SCMI_RST_PIN 8'h0c
`define SCMI_RST_ZERO 8'h00
// writable bits of status register, live status bits
`define SCMI_EDSTAT_WMASK 8'h40
`define SCMI_FULL_MASK 8'hff
`define SCMI_EDSTAT_LIVE_HI 4
`endif

/* File: scmi_pkg.sv */
// types shared by the serial command interpreter
package scmi_pkg;
  typedef enum logic [1:0] {
    SCMI_ST_CMD = 2'b00,
    SCMI_ST_CNT = 2'b01,
    SCMI_ST_WR = 2'b10,
    SCMI_ST_RD = 2'b11
  } scmi_state_t;

  typedef struct packed {
    logic [15:0] ch2;
    logic [15:0] ch1;
  } scmi_sample_t;

  typedef logic [11:0][7:0] scmi_regs_t;

  typedef struct packed {
    scmi_state_t st;
    logic [2:0] bit_cnt;
    logic [7:0] in_sh;
    logic rd;
    logic [4:0] addr;
    logic [4:0] cnt;
    logic cont;
    logic conv_run;
    logic stop_pend;
    logic standby;
    logic cal;
    logic rdata_pend;
    logic [31:0] out_sh;
    logic [5:0] out_left;
    logic started;
    logic dout;
    logic dout_oe;
    logic data_ready_n;
    scmi_sample_t res;
  } scmi_ctl_t;
endpackage

/* File: scmi_sync.sv */
// two-flop synchroniser for the serial pins
`timescale 1ns/1ns
module scmi_sync (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [2:0] i_async,
  output logic [2:0] o_sync
);
  logic [2:0] meta;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      meta <= 3'h4;
      o_sync <= 3'h4;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // scmi_sync

/* File: scmi_buf.sv */
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ns
module scmi_buf (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  input scmi_pkg::scmi_sample_t i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output scmi_pkg::scmi_sample_t o_out_data,
  input wire logic i_out_ready
);
  scmi_pkg::scmi_sample_t mem [2];
  scmi_pkg::scmi_sample_t next_mem [2];
  logic wp, rp, next_wp, next_rp;
  logic [1:0] cnt, next_cnt;
  logic push, pop;

  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_mem = mem;
    next_wp = wp;
    next_rp = rp;
    if (push) begin
      next_mem[wp] = i_in_data;
      next_wp = ~wp;
    end
    if (pop) begin
      next_rp = ~rp;
    end
    next_cnt = 2'(cnt + {1'b0, push} - {1'b0, pop});
  end

  assign o_out_data = mem[rp];

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      mem[0] <= 32'h0000_0000;
      mem[1] <= 32'h0000_0000;
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      mem <= next_mem;
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      o_in_ready <= next_cnt != 2'h2;
      o_out_valid <= next_cnt != 2'h0;
    end
  end
endmodule // scmi_buf

/* File: scmi_core.sv */
// serial command interpreter: opcode decode, register map, result readout
`timescale 1ns/1ns
`include "scmi_regs.svh"
module scmi_core (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe,
  output logic o_data_ready_n,
  input wire logic i_conv_valid,
  input scmi_pkg::scmi_sample_t i_conv_data,
  output logic o_conv_ready,
  input wire logic [4:0] i_electrode_status,
  output logic o_converting,
  output logic o_standby,
  output logic o_offset_cal,
  output scmi_pkg::scmi_regs_t o_regs
);
  scmi_pkg::scmi_ctl_t ctl, next_ctl;
  scmi_pkg::scmi_regs_t regs, next_regs;
  logic [2:0] pin_s;
  logic cs_n_s, sclk_s, din_s, sclk_d;
  logic fall, rise, dec7, dec8, take;
  logic [6:0] p7;
  logic [7:0] b8;
  logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  scmi_pkg::scmi_sample_t buf_out_data;

  function automatic logic [7:0] reg_default(input logic [4:0] a);
    case (a)
      `SCMI_ADDR_IDENT: reg_default = `SCMI_RST_IDENT;
      `SCMI_ADDR_RATE: reg_default = `SCMI_RST_RATE;
      `SCMI_ADDR_REFTST: reg_default = `SCMI_RST_REFTST;
      `SCMI_ADDR_EDCTL: reg_default = `SCMI_RST_EDCTL;
      `SCMI_ADDR_CAL: reg_default = `SCMI_RST_CAL;
      `SCMI_ADDR_PIN: reg_default = `SCMI_RST_PIN;
      default: reg_default = `SCMI_RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] wr_mask(input logic [4:0] a);
    if (a == `SCMI_ADDR_IDENT || a > `SCMI_ADDR_LAST) begin
      wr_mask = `SCMI_RST_ZERO;
    end else if (a == `SCMI_ADDR_EDSTAT) begin
      wr_mask = `SCMI_EDSTAT_WMASK;
    end else begin
      wr_mask = `SCMI_FULL_MASK;
    end
  endfunction

  function automatic logic [7:0] rd_val(input scmi_pkg::scmi_regs_t r, input logic [4:0] a);
    if (a > `SCMI_ADDR_LAST) begin
      rd_val = `SCMI_RST_ZERO;
    end else begin
      rd_val = r[a[3:0]];
    end
  endfunction

  scmi_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_async({i_cs_n, i_sclk, i_din}),
    .o_sync(pin_s)
  );

  scmi_buf u_buf (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_in_valid(buf_in_valid),
    .i_in_data(i_conv_data),
    .o_in_ready(buf_in_ready),
    .o_out_valid(buf_out_valid),
    .o_out_data(buf_out_data),
    .i_out_ready(buf_out_ready)
  );

  assign cs_n_s = pin_s[2];
  assign sclk_s = pin_s[1];
  assign din_s = pin_s[0];
  assign fall = sclk_d && !sclk_s && !cs_n_s;
  assign rise = !sclk_d && sclk_s && !cs_n_s;
  assign p7 = {ctl.in_sh[5:0], din_s};
  assign b8 = {ctl.in_sh[6:0], din_s};
  assign dec7 = fall && ctl.bit_cnt == `SCMI_BIT_SYS && ctl.st == scmi_pkg::SCMI_ST_CMD;
  assign dec8 = fall && ctl.bit_cnt == `SCMI_BIT_BYTE;
  // conversions enter the buffer only while running
  assign buf_in_valid = i_conv_valid && ctl.conv_run;
  // no reload during a transfer, one idle cycle before each data-ready
  assign buf_out_ready = !ctl.started && ctl.data_ready_n;
  assign take = buf_out_valid && buf_out_ready;

  always_comb begin
    next_ctl = ctl;
    next_regs = regs;
    next_regs[`SCMI_ADDR_EDSTAT][`SCMI_EDSTAT_LIVE_HI:0] = i_electrode_status;
    next_ctl.cal = 1'b0;
    if (cs_n_s) begin
      next_ctl.bit_cnt = 3'h0;
      next_ctl.st = scmi_pkg::SCMI_ST_CMD;
      next_ctl.started = 1'b0;
      next_ctl.dout_oe = 1'b0;
      next_ctl.rdata_pend = 1'b0;
    end else begin
      next_ctl.dout_oe = 1'b1;
      if (fall) begin
        next_ctl.in_sh = b8;
        next_ctl.bit_cnt = 3'(ctl.bit_cnt + 3'h1);
      end
      // system and single-read opcodes
      if (dec7) begin
        case (p7)
          `SCMI_P7_WAKE: next_ctl.standby = 1'b0;
          `SCMI_P7_STANDBY: next_ctl.standby = 1'b1;
          `SCMI_P7_RESET: begin
            for (int i = 0; i < 12; i++) begin
              next_regs[i] = reg_default(5'(i));
            end
            next_ctl.cont = 1'b1;
            next_ctl.conv_run = 1'b0;
            next_ctl.stop_pend = 1'b0;
            next_ctl.standby = 1'b0;
          end
          `SCMI_P7_START: begin
            if (!ctl.conv_run) begin
              next_ctl.conv_run = 1'b1;
              next_ctl.stop_pend = 1'b0;
            end
          end
          `SCMI_P7_STOP: begin
            if (ctl.conv_run) begin
              next_ctl.stop_pend = 1'b1;
            end
          end
          `SCMI_P7_CAL: next_ctl.cal = 1'b1;
          `SCMI_P7_RDATA: next_ctl.rdata_pend = !ctl.cont;
          default: next_ctl.cal = 1'b0;
        endcase
      end
      // full-byte decode
      if (dec8) begin
        case (ctl.st)
          scmi_pkg::SCMI_ST_CMD: begin
            if (ctl.rdata_pend) begin
              next_ctl.out_sh = ctl.res;
              next_ctl.out_left = `SCMI_DATA_BITS;
              next_ctl.rdata_pend = 1'b0;
            end
            if (b8 == `SCMI_OP_CONT_READ) begin
              next_ctl.cont = 1'b1;
            end else if (b8 == `SCMI_OP_HALT_READ) begin
              next_ctl.cont = 1'b0;
            end else if (b8[7:5] == `SCMI_PFX_REG_READ && !ctl.cont) begin
              next_ctl.addr = b8[4:0];
              next_ctl.rd = 1'b1;
              next_ctl.st = scmi_pkg::SCMI_ST_CNT;
            end else if (b8[7:5] == `SCMI_PFX_REG_WRITE) begin
              next_ctl.addr = b8[4:0];
              next_ctl.rd = 1'b0;
              next_ctl.st = scmi_pkg::SCMI_ST_CNT;
            end
          end
          scmi_pkg::SCMI_ST_CNT: begin
            next_ctl.cnt = b8[4:0];
            if (ctl.rd) begin
              next_ctl.st = scmi_pkg::SCMI_ST_RD;
              next_ctl.out_sh = {rd_val(regs, ctl.addr), 24'h00_0000};
              next_ctl.out_left = `SCMI_REG_BITS;
            end else begin
              next_ctl.st = scmi_pkg::SCMI_ST_WR;
            end
          end
          scmi_pkg::SCMI_ST_WR: begin
            if (ctl.addr <= `SCMI_ADDR_LAST) begin
              next_regs[ctl.addr[3:0]] = (next_regs[ctl.addr[3:0]] & ~wr_mask(ctl.addr))
                                         | (b8 & wr_mask(ctl.addr));
            end
            if (ctl.cnt == 5'h00) begin
              next_ctl.st = scmi_pkg::SCMI_ST_CMD;
            end else begin
              next_ctl.cnt = 5'(ctl.cnt - 5'h01);
              next_ctl.addr = 5'(ctl.addr + 5'h01);
            end
          end
          scmi_pkg::SCMI_ST_RD: begin
            if (ctl.cnt == 5'h00) begin
              next_ctl.st = scmi_pkg::SCMI_ST_CMD;
            end else begin
              next_ctl.cnt = 5'(ctl.cnt - 5'h01);
              next_ctl.addr = 5'(ctl.addr + 5'h01);
              next_ctl.out_sh = {rd_val(regs, 5'(ctl.addr + 5'h01)), 24'h00_0000};
              next_ctl.out_left = `SCMI_REG_BITS;
            end
          end
          default: next_ctl.st = scmi_pkg::SCMI_ST_CMD;
        endcase
      end
      // shift out on rising edges
      if (rise && ctl.out_left != 6'h00) begin
        next_ctl.dout = ctl.out_sh[31];
        next_ctl.out_sh = {ctl.out_sh[30:0], 1'b0};
        next_ctl.out_left = 6'(ctl.out_left - 6'h01);
        next_ctl.started = ctl.out_left != 6'h01;
      end
    end
    // stop takes effect when the running conversion is delivered
    if (buf_in_valid && buf_in_ready && ctl.stop_pend) begin
      next_ctl.conv_run = 1'b0;
      next_ctl.stop_pend = 1'b0;
    end
    if (take) begin
      next_ctl.res = buf_out_data;
      next_ctl.data_ready_n = 1'b0;
      if (ctl.cont) begin
        next_ctl.out_sh = buf_out_data;
        next_ctl.out_left = `SCMI_DATA_BITS;
      end
    end else if (buf_out_valid && !ctl.data_ready_n && !ctl.started) begin
      next_ctl.data_ready_n = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      ctl <= '0;
      ctl.cont <= 1'b1;
      ctl.data_ready_n <= 1'b1;
      sclk_d <= 1'b0;
      for (int i = 0; i < 12; i++) begin
        regs[i] <= reg_default(5'(i));
      end
    end else begin
      ctl <= next_ctl;
      sclk_d <= sclk_s;
      regs <= next_regs;
    end
  end

  assign o_dout = ctl.dout;
  assign o_dout_oe = ctl.dout_oe;
  assign o_data_ready_n = ctl.data_ready_n;
  assign o_conv_ready = buf_in_ready;
  assign o_converting = ctl.conv_run;
  assign o_standby = ctl.standby;
  assign o_offset_cal = ctl.cal;
  assign o_regs = regs;

  property p_start_run;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    dec7 && p7 == `SCMI_P7_START && !ctl.conv_run |=> ctl.conv_run && !ctl.stop_pend;
  endproperty
  a_start_run: assert property (p_start_run) else $error("start did not run");

  property p_start_noeff;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    dec7 && p7 == `SCMI_P7_START && ctl.conv_run && !buf_in_valid
      |=> ctl.conv_run && ctl.stop_pend == $past(ctl.stop_pend);
  endproperty
  a_start_noeff: assert property (p_start_noeff) else $error("start changed state");

  property p_stop_pend;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    dec7 && p7 == `SCMI_P7_STOP && ctl.conv_run && !buf_in_valid |=> ctl.stop_pend && ctl.conv_run;
  endproperty
  a_stop_pend: assert property (p_stop_pend) else $error("stop cut conversion");

  property p_stop_idle;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    dec7 && p7 == `SCMI_P7_STOP && !ctl.conv_run |=> !ctl.stop_pend && !ctl.conv_run;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop acted when idle");

  property p_register_read_cmd_ignored;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    dec8 && ctl.st == scmi_pkg::SCMI_ST_CMD && ctl.cont && b8[7:5] == `SCMI_PFX_REG_READ
      |=> ctl.st == scmi_pkg::SCMI_ST_CMD;
  endproperty
  a_register_read_cmd_ignored: assert property (p_register_read_cmd_ignored) else $error("read taken in cont");

  property p_rd_first;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    dec8 && ctl.st == scmi_pkg::SCMI_ST_CNT && ctl.rd
      |=> ctl.out_left == `SCMI_REG_BITS && ctl.out_sh[31:24] == rd_val(regs, ctl.addr);
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("register not loaded");

  property p_cont_load;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    take && ctl.cont |=> ctl.out_sh == $past(buf_out_data) && !ctl.data_ready_n;
  endproperty
  a_cont_load: assert property (p_cont_load) else $error("result not loaded");

  property p_no_corrupt;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    ctl.started && !rise && !dec8 |=> $stable(ctl.out_sh);
  endproperty
  a_no_corrupt: assert property (p_no_corrupt) else $error("reload during transfer");

  property p_nop;
    @(posedge i_ref_clk) disable iff (!i_resetn)
    dec8 && ctl.st == scmi_pkg::SCMI_ST_CMD && b8 == 8'hff && !ctl.rdata_pend
      |=> $stable(ctl.cont) && ctl.st == scmi_pkg::SCMI_ST_CMD && $stable(regs[1]);
  endproperty
  a_nop: assert property (p_nop) else $error("unknown byte had effect");
endmodule // scmi_core

/* File: scmi_host.sv */
// host-side serial bus master model for the serial command interpreter
`timescale 1ns/1ns
module scmi_host (
  input wire logic i_ref_clk,
  input wire logic i_dout,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  initial begin
    o_cs_n = 1'h1;
    o_sclk = 1'h0;
    o_din = 1'h0;
  end

  // select, then let the pin synchroniser settle
  task automatic frame_begin();
    @(posedge i_ref_clk);
    o_cs_n <= 1'h0;
    repeat (4) @(posedge i_ref_clk);
  endtask

  // serial clock stands low, data line shows inverse once released
  task automatic frame_end();
    repeat (4) @(posedge i_ref_clk);
    o_cs_n <= 1'h1;
    o_din <= ~o_din;
    repeat (8) @(posedge i_ref_clk);
  endtask

  // one byte msb first, data out read just before the next rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      o_sclk <= 1'h1;
      o_din <= tx[i];
      repeat (4) @(posedge i_ref_clk);
      o_sclk <= 1'h0;
      repeat (4) @(posedge i_ref_clk);
      rx = {rx[6:0], i_dout};
    end
    o_din <= ~o_din;
    repeat (8) @(posedge i_ref_clk);
  endtask
endmodule // scmi_host

/* File: scmi_tb_top.sv */
// self-checking bench for the serial command interpreter
`timescale 1ns/1ns
`include "scmi_regs.svh"
module scmi_tb_top;
  logic clk;
  logic resetn;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic miso;
  logic miso_last = 1'h0;
  logic data_ready_n;
  logic conv_valid;
  scmi_pkg::scmi_sample_t conv_data;
  logic conv_ready;
  logic [4:0] status;
  logic converting;
  logic standby;
  logic offset_cal;
  scmi_pkg::scmi_regs_t regs;
  int fail_count = 0;
  int checks = 0;
  int cal_pulses = 0;
  int c0;
  logic [7:0] expv [13];
  logic [7:0] wdat [13];
  logic [7:0] unk [3] = '{8'hff, 8'h80, 8'hc5};
  logic [7:0] rx;
  logic [31:0] word;

  scmi_core DUT (
    .i_ref_clk(clk),
    .i_resetn(resetn),
    .i_cs_n(cs_n),
    .i_sclk(sclk),
    .i_din(din),
    .o_dout(dout),
    .o_dout_oe(dout_oe),
    .o_data_ready_n(data_ready_n),
    .i_conv_valid(conv_valid),
    .i_conv_data(conv_data),
    .o_conv_ready(conv_ready),
    .i_electrode_status(status),
    .o_converting(converting),
    .o_standby(standby),
    .o_offset_cal(offset_cal),
    .o_regs(regs)
  );

  scmi_host host (
    .i_ref_clk(clk),
    .i_dout(miso),
    .o_cs_n(cs_n),
    .o_sclk(sclk),
    .o_din(din)
  );

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // released data-out line shows the inverse of its last level
  always @(posedge clk) if (dout_oe === 1'h1) miso_last <= dout;
  assign miso = dout_oe ? dout : ~miso_last;
  always @(posedge clk) if (offset_cal === 1'h1) cal_pulses++;

  task automatic stop_test();
    if (fail_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // 0 data ready, 1 converting, 2 converter ready
  task automatic wait_lvl(input int sel, input logic v);
    logic s;
    for (int n = 0; n < 4000; n++) begin
      @(posedge clk);
      s = (sel == 0) ? data_ready_n : (sel == 1) ? converting : conv_ready;
      if (s === v) return;
    end
    fail_count++;
    stop_test();
  endtask

  task automatic push(input logic [31:0] d);
    @(posedge clk);
    conv_valid <= 1'h1;
    conv_data <= d;
    for (int n = 0; n < 4000; n++) begin
      @(posedge clk);
      if (conv_ready === 1'h1 && converting === 1'h1) begin
        conv_valid <= 1'h0;
        return;
      end
    end
    fail_count++;
    stop_test();
  endtask

  task automatic send(input logic [7:0] b);
    host.frame_begin();
    host.xfer(b, rx);
    host.frame_end();
  endtask

  task automatic read_word(output logic [31:0] w);
    w = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      host.xfer(8'h00, rx);
      w = {w[23:0], rx};
    end
  endtask

  task automatic load_dflt();
    expv = '{`SCMI_RST_IDENT, 8'h02, 8'h80, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
             {3'h0, status}, 8'h00, 8'h02, 8'h0c, 8'h00};
  endtask

  task automatic check_regs();
    for (int i = 0; i < 12; i++)
      check({24'h00_0000, regs[i]}, {24'h00_0000, expv[i]});
  endtask

  // thirteen registers from address zero, one past the map
  task automatic rw_all(input logic wr);
    host.frame_begin();
    host.xfer(wr ? 8'h40 : 8'h20, rx);
    host.xfer(8'h0c, rx);
    for (int i = 0; i < 13; i++) begin
      host.xfer(wr ? wdat[i] : 8'h00, rx);
      if (!wr) check({24'h00_0000, rx}, {24'h00_0000, expv[i]});
    end
    host.frame_end();
  endtask

  initial begin
    resetn = 1'h0;
    conv_valid = 1'h0;
    conv_data = 32'h0000_0000;
    status = 5'h00;
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    repeat (4) @(posedge clk);
    load_dflt();
    check_regs();
    check({26'h0, dout_oe, data_ready_n, conv_ready, converting, standby, offset_cal},
          32'h0000_0018);
    status <= 5'h15;
    host.frame_begin();
    host.xfer(8'h20, rx);
    host.xfer(8'h00, rx);
    host.xfer(8'h08, rx);
    host.frame_end();
    check({31'h0, converting}, 32'h0000_0001);
    send(8'h08);
    check({31'h0, converting}, 32'h0000_0001);
    push(32'h1234_abcd);
    wait_lvl(0, 1'h0);
    repeat (8) @(posedge clk);
    host.frame_begin();
    read_word(word);
    host.frame_end();
    check(word, 32'h1234_abcd);
    send(8'h11);
    send(8'h0a);
    check({31'h0, converting}, 32'h0000_0001);
    push(32'h5a5a_0f0f);
    repeat (4) @(posedge clk);
    check({31'h0, converting}, 32'h0000_0000);
    send(8'h0a);
    check({31'h0, converting}, 32'h0000_0000);
    send(8'h08);
    check({31'h0, converting}, 32'h0000_0001);
    for (int i = 0; i < 13; i++) wdat[i] = 8'hc3 ^ {i[3:0], i[3:0]};
    wdat[10] = 8'h82;
    for (int i = 1; i < 12; i++) expv[i] = wdat[i];
    expv[8] = (wdat[8] & 8'h40) | {3'h0, status};
    rw_all(1'h1);
    check_regs();
    rw_all(1'h0);
    c0 = cal_pulses;
    send(8'h1a);
    check(cal_pulses - c0, 32'h0000_0001);
    foreach (unk[k]) begin
      send(unk[k]);
      check_regs();
    end
    check({30'h0, converting, standby}, 32'h0000_0002);
    send(8'h04);
    check({31'h0, standby}, 32'h0000_0001);
    send(8'h02);
    check({31'h0, standby}, 32'h0000_0000);
    send(8'h06);
    load_dflt();
    check_regs();
    send(8'h11);
    send(8'h08);
    push(32'hbeef_1357);
    repeat (8) @(posedge clk);
    wait_lvl(0, 1'h0);
    fork
      begin
        host.frame_begin();
        host.xfer(8'h12, rx);
        read_word(word);
        host.frame_end();
      end
      begin
        repeat (120) @(posedge clk);
        push(32'h0246_8ace);
        push(32'h1357_9bdf);
        @(posedge clk);
        check({31'h0, conv_ready}, 32'h0000_0000);
      end
    join
    check(word, 32'hbeef_1357);
    send(8'h10);
    push(32'h7e81_c33c);
    repeat (16) @(posedge clk);
    wait_lvl(0, 1'h0);
    repeat (8) @(posedge clk);
    host.frame_begin();
    read_word(word);
    host.frame_end();
    check(word, 32'h7e81_c33c);
    stop_test();
  end
endmodule // scmi_tb_top
